// ==== src/hsd_pkg.sv ====
// package: register map, field positions and carriers for the hose status/diagnostic bank
package hsd_pkg;
	localparam int NUM_SLICES = 4;
	localparam logic [15:0] OFF_DIAG0 = 16'h2a80;
	localparam logic [15:0] OFF_DIAG1 = 16'h2180;
	localparam logic [15:0] OFF_DIAG2 = 16'h2280;
	localparam logic [15:0] OFF_DIAG3 = 16'h2380;
	localparam logic [15:0] OFF_STAT0 = 16'h2a40;
	localparam logic [15:0] OFF_STAT1 = 16'h2140;
	localparam logic [15:0] OFF_STAT2 = 16'h2240;
	localparam logic [15:0] OFF_STAT3 = 16'h2340;
	localparam logic [15:0] OFF_VECTOR = 16'h2b40;
	// status register fields
	localparam int BIT_HOSE_RESET = 31;
	localparam int BIT_PWR_TRANS = 3;
	localparam int BIT_CABLE = 2;
	localparam int BIT_PWR_LEVEL = 1;
	localparam int BIT_ADAPTER_ERR = 0;
	// diagnostic register fields
	localparam int BIT_VMARGIN = 31;
	localparam int BIT_SUPPRESS_RST = 30;
	localparam int BIT_EARLY_EOP = 20;
	localparam int BIT_EXTRA_VALID = 19;
	localparam int BIT_DN_PARITY = 18;
	localparam int BIT_CSR_APE = 17;
	localparam int BIT_CSR_DPE = 16;
	localparam int ECC_WIDTH = 8;
	localparam int VECTOR_WIDTH = 16;
	localparam logic [31:0] DIAG_RESET = 32'h0000_0000;
	localparam logic [15:0] VECTOR_RESET = 16'h0000;

	// csr request from the system bus side
	typedef struct packed {
		logic valid;
		logic write;
		logic [15:0] offset;
		logic [31:0] wdata;
	} hsd_csr_req_t;

	// per-hose inputs from the cable
	typedef struct packed {
		logic power_good;
		logic cable_good;
		logic adapter_fatal;
	} hsd_hose_in_t;

	// per-slice error forcing controls toward the data paths
	typedef struct packed {
		logic early_eop;
		logic extra_valid;
		logic dn_parity;
		logic csr_addr_parity;
		logic csr_data_parity;
		logic [7:0] ecc_flip;
	} hsd_force_t;
endpackage

// ==== src/hsd_regs.sv ====
// hose status, error forcing and error vector registers of the four data path slices
// Notes on behaviour
// - power-transition flag bit 3 sets on a power-good level change seen outside reset with clock enable high; write one clears.
// - bit 1 shows live power-good level; it never raises interrupts.
// - flag or hose error setting raises level-17 interrupt only when node enable set.
// - bit 2 is read-only cable-good copy, never interrupts.
// - four slices, identical except for bits 16 and 31; slice n reports hose n only.
// - diag bit 31 drives margin: slices 0/1 main converter up/down, 2/3 low converter.
// - raise and lower both set leaves that converter nominal.
// - margin bit survives node reset, cleared only by power-up reset.
// - diag bit 30 suppresses downstream hose reset of hose n during node reset.
// - diag bit 20 forces early end-of-packet on mailbox command packets.
// - diag bit 19 holds downstream valid one extra cycle on mailbox packets.
// - diag bit 18 forces wrong downstream parity, per slice.
// - write-only bit 17 corrupts csr address parity; clears after next csr access.
// - slice 0 bit 16 corrupts csr write data parity seen by other targets.
// - slices 1-3 bit 16 make reads of that slice log parity error in slice 0.
// - force-ecc bits invert matching check bits on read return data.
// - software-loaded 16-bit vector returned on level-3 interrupt identification read.
// - writing one to status bit 31 resets that hose; reads return zero.
`timescale 1ns/100ps
module hsd_regs
	import hsd_pkg::*;
#(
	parameter int SLICES = NUM_SLICES
)
(
	input wire logic clock,
	input wire logic reset,
	input wire logic power_up_reset,
	input wire logic clock_enable,
	input wire hsd_csr_req_t csr_req,
	output logic [31:0] csr_rdata,
	output logic csr_ack,
	input wire hsd_hose_in_t [SLICES-1:0] hose_in,
	input wire logic node_specific_irq_enable,
	output logic level17_irq,
	input wire logic node_reset_active,
	output logic [SLICES-1:0] downstream_hose_reset_n,
	output logic [SLICES-1:0] hose_reset_request,
	output hsd_force_t [SLICES-1:0] force_ctl,
	output logic main_margin_up,
	output logic main_margin_down,
	output logic low_margin_up,
	output logic low_margin_down,
	input wire logic [7:0] ecc_in,
	input wire logic read_return_valid,
	output logic [7:0] ecc_out,
	input wire logic level3_ident_read,
	output logic [15:0] level3_ident_data,
	input wire logic [SLICES-1:0] slice_write_target,
	input wire logic [SLICES-1:0] slice_read_target,
	output logic [SLICES-1:0] slice_csr_bus_parity_err,
	output logic ctl_csr_bus_parity_err
);

	function automatic logic [15:0] stat_off(input int n);
		case (n)
			0: stat_off = OFF_STAT0;
			1: stat_off = OFF_STAT1;
			2: stat_off = OFF_STAT2;
			default: stat_off = OFF_STAT3;
		endcase
	endfunction

	function automatic logic [15:0] diag_off(input int n);
		case (n)
			0: diag_off = OFF_DIAG0;
			1: diag_off = OFF_DIAG1;
			2: diag_off = OFF_DIAG2;
			default: diag_off = OFF_DIAG3;
		endcase
	endfunction

	logic [SLICES-1:0] pwr_prev;
	logic [SLICES-1:0] pwr_trans;
	logic [SLICES-1:0] err_prev;
	logic [SLICES-1:0] vmargin;
	logic [SLICES-1:0] suppress_rst;
	logic [SLICES-1:0] early_eop;
	logic [SLICES-1:0] extra_valid;
	logic [SLICES-1:0] dn_parity;
	logic [SLICES-1:0] csr_ape;
	logic [SLICES-1:0] csr_dpe;
	logic [SLICES-1:0][7:0] ecc_force;
	logic [15:0] err_vector;
	logic [SLICES-1:0] stat_hit;
	logic [SLICES-1:0] diag_hit;
	logic [SLICES-1:0] trans_event;
	logic [SLICES-1:0] err_rise;
	logic vec_hit;
	logic access;
	logic [7:0] ecc_mask;

	assign access = clock_enable && csr_req.valid;
	assign vec_hit = csr_req.offset == OFF_VECTOR;

	genvar g;
	generate
		for (g = 0; g < SLICES; g++)
		begin : g_slice
			assign stat_hit[g] = csr_req.offset == stat_off(g);
			assign diag_hit[g] = csr_req.offset == diag_off(g);
			assign trans_event[g] = hose_in[g].power_good != pwr_prev[g];
			assign err_rise[g] = hose_in[g].adapter_fatal && !err_prev[g];
			assign force_ctl[g].early_eop = early_eop[g];
			assign force_ctl[g].extra_valid = extra_valid[g];
			assign force_ctl[g].dn_parity = dn_parity[g];
			assign force_ctl[g].csr_addr_parity = csr_ape[g];
			assign force_ctl[g].csr_data_parity = csr_dpe[g];
			assign force_ctl[g].ecc_flip = ecc_force[g];
			// suppression only masks the node reset, an explicit hose reset still goes out
			assign downstream_hose_reset_n[g] =
				!((node_reset_active && !suppress_rst[g]) || hose_reset_request[g]);
		end
	endgenerate

	// edge detectors follow the pins through reset, so a hose that is already powered
	// does not look like a fresh transition once reset lets go
	always_ff @(posedge clock)
	begin
		if (reset || clock_enable)
		begin
			for (int i = 0; i < SLICES; i++)
			begin
				pwr_prev[i] <= hose_in[i].power_good;
				err_prev[i] <= hose_in[i].adapter_fatal;
			end
		end
	end

	// sticky transition flags, set beats clear
	always_ff @(posedge clock)
	begin
		if (reset)
			pwr_trans <= '0;
		else if (clock_enable)
		begin
			for (int i = 0; i < SLICES; i++)
			begin
				if (trans_event[i])
					pwr_trans[i] <= 1'b1;
				else if (access && csr_req.write && stat_hit[i] && csr_req.wdata[BIT_PWR_TRANS])
					pwr_trans[i] <= 1'b0;
			end
		end
	end

	// hose reset pulse, one cycle per write of one
	always_ff @(posedge clock)
	begin
		if (reset)
			hose_reset_request <= '0;
		else if (clock_enable)
		begin
			for (int i = 0; i < SLICES; i++)
				hose_reset_request[i] <= access && csr_req.write && stat_hit[i]
					&& csr_req.wdata[BIT_HOSE_RESET];
		end
	end

	// margin and hose-reset suppression live on the power-up reset, a node reset must not undo them
	always_ff @(posedge clock)
	begin
		if (power_up_reset)
		begin
			vmargin <= '0;
			suppress_rst <= '0;
		end
		else if (clock_enable && csr_req.valid && csr_req.write)
		begin
			for (int i = 0; i < SLICES; i++)
			begin
				if (diag_hit[i])
				begin
					vmargin[i] <= csr_req.wdata[BIT_VMARGIN];
					suppress_rst[i] <= csr_req.wdata[BIT_SUPPRESS_RST];
				end
			end
		end
	end

	// diagnostic controls
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			early_eop <= '0;
			extra_valid <= '0;
			dn_parity <= '0;
			csr_dpe <= '0;
			ecc_force <= '0;
		end
		else if (access && csr_req.write)
		begin
			for (int i = 0; i < SLICES; i++)
			begin
				if (diag_hit[i])
				begin
					early_eop[i] <= csr_req.wdata[BIT_EARLY_EOP];
					extra_valid[i] <= csr_req.wdata[BIT_EXTRA_VALID];
					dn_parity[i] <= csr_req.wdata[BIT_DN_PARITY];
					csr_dpe[i] <= csr_req.wdata[BIT_CSR_DPE];
					ecc_force[i] <= csr_req.wdata[ECC_WIDTH-1:0];
				end
			end
		end
	end

	// address parity force arms on its write and clears on the next access of any kind
	always_ff @(posedge clock)
	begin
		if (reset)
			csr_ape <= '0;
		else if (access)
		begin
			for (int i = 0; i < SLICES; i++)
			begin
				if (csr_req.write && diag_hit[i] && csr_req.wdata[BIT_CSR_APE])
					csr_ape[i] <= 1'b1;
				else
					csr_ape[i] <= 1'b0;
			end
		end
	end

	// error vector
	always_ff @(posedge clock)
	begin
		if (reset)
			err_vector <= VECTOR_RESET;
		else if (access && csr_req.write && vec_hit)
			err_vector <= csr_req.wdata[VECTOR_WIDTH-1:0];
	end

	// read data and acknowledge
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			csr_rdata <= '0;
			csr_ack <= 1'b0;
		end
		else if (clock_enable)
		begin
			csr_ack <= csr_req.valid;
			csr_rdata <= '0;
			if (csr_req.valid && !csr_req.write)
			begin
				for (int i = 0; i < SLICES; i++)
				begin
					if (stat_hit[i])
					begin
						csr_rdata[BIT_PWR_TRANS] <= pwr_trans[i];
						csr_rdata[BIT_CABLE] <= hose_in[i].cable_good;
						csr_rdata[BIT_PWR_LEVEL] <= hose_in[i].power_good;
						csr_rdata[BIT_ADAPTER_ERR] <= hose_in[i].adapter_fatal;
					end
					if (diag_hit[i])
					begin
						csr_rdata[BIT_VMARGIN] <= vmargin[i];
						csr_rdata[BIT_SUPPRESS_RST] <= suppress_rst[i];
						csr_rdata[BIT_EARLY_EOP] <= early_eop[i];
						csr_rdata[BIT_EXTRA_VALID] <= extra_valid[i];
						csr_rdata[BIT_DN_PARITY] <= dn_parity[i];
						csr_rdata[BIT_CSR_DPE] <= csr_dpe[i];
						csr_rdata[ECC_WIDTH-1:0] <= ecc_force[i];
					end
				end
				if (vec_hit)
					csr_rdata[VECTOR_WIDTH-1:0] <= err_vector;
			end
		end
	end

	// level-3 ident read returns the vector
	always_ff @(posedge clock)
	begin
		if (reset)
			level3_ident_data <= '0;
		else if (clock_enable && level3_ident_read)
			level3_ident_data <= err_vector;
	end

	// interrupt: only transition flags and adapter errors count, never the levels
	always_ff @(posedge clock)
	begin
		if (reset)
			level17_irq <= 1'b0;
		else if (clock_enable)
			level17_irq <= node_specific_irq_enable && ((|trans_event) || (|err_rise));
	end

	// check bit inversion on read return
	always_comb
	begin
		ecc_mask = '0;
		for (int i = 0; i < SLICES; i++)
			ecc_mask = ecc_mask | ecc_force[i];
	end

	always_ff @(posedge clock)
	begin
		if (reset)
			ecc_out <= '0;
		else if (clock_enable)
			ecc_out <= read_return_valid ? (ecc_in ^ ecc_mask) : ecc_in;
	end

	// internal csr bus parity error outcomes
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			slice_csr_bus_parity_err <= '0;
			ctl_csr_bus_parity_err <= 1'b0;
		end
		else if (clock_enable)
		begin
			for (int i = 0; i < SLICES; i++)
			begin
				if (i == 0)
					slice_csr_bus_parity_err[i] <= (access && csr_ape[i])
						|| (|(slice_read_target[SLICES-1:1] & csr_dpe[SLICES-1:1]));
				else
					slice_csr_bus_parity_err[i] <= (access && csr_ape[i])
						|| (slice_write_target[i] && csr_dpe[0]);
			end
			ctl_csr_bus_parity_err <= csr_dpe[0] && slice_write_target[0] == 1'b0
				&& access && csr_req.write && !(|stat_hit) && !(|diag_hit) && !vec_hit;
		end
	end

	// converter margin: conflicting requests cancel to nominal
	assign main_margin_up = vmargin[0] && !vmargin[1];
	assign main_margin_down = vmargin[1] && !vmargin[0];
	assign low_margin_up = vmargin[2] && !vmargin[3];
	assign low_margin_down = vmargin[3] && !vmargin[2];

	property p_margin_conflict;
		@(posedge clock) disable iff (power_up_reset)
			(vmargin[0] && vmargin[1]) |-> !main_margin_up && !main_margin_down;
	endproperty
	a_margin_conflict: assert property (p_margin_conflict) else $error("margin conflict not nominal");

	property p_trans_sets;
		@(posedge clock) disable iff (reset)
			(clock_enable && trans_event[1]) |=> pwr_trans[1];
	endproperty
	a_trans_sets: assert property (p_trans_sets) else $error("transition flag did not set");

	property p_trans_holds;
		@(posedge clock) disable iff (reset)
			(pwr_trans[1] && !(access && csr_req.write && stat_hit[1])) |=> pwr_trans[1];
	endproperty
	a_trans_holds: assert property (p_trans_holds) else $error("transition flag lost");

	property p_irq_gated;
		@(posedge clock) disable iff (reset)
			(clock_enable && !node_specific_irq_enable) |=> !level17_irq;
	endproperty
	a_irq_gated: assert property (p_irq_gated) else $error("interrupt while disabled");

	property p_irq_on_err;
		@(posedge clock) disable iff (reset)
			(clock_enable && node_specific_irq_enable && err_rise[2]) |=> level17_irq;
	endproperty
	a_irq_on_err: assert property (p_irq_on_err) else $error("no interrupt on hose error");

	property p_hose_reset;
		@(posedge clock) disable iff (reset)
			(access && csr_req.write && stat_hit[2] && csr_req.wdata[BIT_HOSE_RESET])
				|=> hose_reset_request[2] && !downstream_hose_reset_n[2];
	endproperty
	a_hose_reset: assert property (p_hose_reset) else $error("hose reset not issued");

	property p_suppress;
		@(posedge clock) disable iff (reset)
			(suppress_rst[0] && !hose_reset_request[0]) |-> downstream_hose_reset_n[0];
	endproperty
	a_suppress: assert property (p_suppress) else $error("suppressed hose reset asserted");

	property p_ape_clears;
		@(posedge clock) disable iff (reset)
			(csr_ape[0] && access && !(csr_req.write && diag_hit[0] && csr_req.wdata[BIT_CSR_APE]))
				|=> !csr_ape[0];
	endproperty
	a_ape_clears: assert property (p_ape_clears) else $error("address parity force stuck");

	property p_vector;
		@(posedge clock) disable iff (reset)
			(clock_enable && level3_ident_read) |=> level3_ident_data == $past(err_vector);
	endproperty
	a_vector: assert property (p_vector) else $error("wrong ident vector");

endmodule // hsd_regs

// ==== bench/hsd_adapter_model.sv ====
// behavioural model of the four hose adapters on the far side of the cables
`timescale 1ns/100ps
module hsd_adapter_model
	import hsd_pkg::*;
(
	input wire logic clock,
	input wire logic [3:0] power_set,
	input wire logic [3:0] cable_set,
	input wire logic [3:0] fatal_event,
	input wire logic [3:0] hose_reset_request,
	output hsd_hose_in_t [3:0] hose_in
);
	logic [3:0] fatal_held = 4'h0;

	// a fatal adapter keeps signalling until its own hose reset arrives
	always_ff @(posedge clock)
	begin
		fatal_held <= (fatal_held | fatal_event) & ~hose_reset_request;
	end

	always_comb
	begin
		for (int i = 0; i < 4; i++)
		begin
			hose_in[i].power_good = power_set[i];
			hose_in[i].cable_good = cable_set[i];
			hose_in[i].adapter_fatal = fatal_held[i];
		end
	end
endmodule // hsd_adapter_model

// ==== bench/hsd_regs_tb.sv ====
// self-checking bench for the hose status and diagnostic register bank
`timescale 1ns/100ps
module hsd_regs_tb;
	import hsd_pkg::*;
	logic clock = 0, reset = 1, power_up_reset = 1, irq_en = 0, node_reset_active = 0, ce = 1, pe_clear = 0;
	logic read_return_valid = 0, level3_ident_read = 0, csr_ack, irq, ctl_pe, mu, md, lu, ld;
	logic [7:0] ecc_in = 8'h00, ecc_out;
	logic [3:0] power_set = 4'h0, cable_set = 4'h9, fatal_event = 4'h0, wr_target = 4'h0, rd_target = 4'h0;
	logic [3:0] dn_rst_n, hose_rst, pe_err, pe_seen = 4'h0;
	logic [31:0] rdata, csr_rdata;
	logic [15:0] ident;
	hsd_csr_req_t req = '0;
	hsd_hose_in_t [3:0] hose_in;
	hsd_force_t [3:0] force_ctl;
	int error_cnt = 0, tests_run = 0, irq_cnt = 0, ctl_cnt = 0;
	localparam logic [15:0] STAT[4] = '{OFF_STAT0, OFF_STAT1, OFF_STAT2, OFF_STAT3};
	localparam logic [15:0] DIAG[4] = '{OFF_DIAG0, OFF_DIAG1, OFF_DIAG2, OFF_DIAG3};

	hsd_regs u_hsd_regs (.clock(clock), .reset(reset), .power_up_reset(power_up_reset), .clock_enable(ce),
		.csr_req(req), .csr_rdata(csr_rdata), .csr_ack(csr_ack), .hose_in(hose_in),
		.node_specific_irq_enable(irq_en), .level17_irq(irq), .node_reset_active(node_reset_active),
		.downstream_hose_reset_n(dn_rst_n), .hose_reset_request(hose_rst), .force_ctl(force_ctl),
		.main_margin_up(mu), .main_margin_down(md), .low_margin_up(lu), .low_margin_down(ld),
		.ecc_in(ecc_in), .read_return_valid(read_return_valid), .ecc_out(ecc_out),
		.level3_ident_read(level3_ident_read), .level3_ident_data(ident), .slice_write_target(wr_target),
		.slice_read_target(rd_target), .slice_csr_bus_parity_err(pe_err), .ctl_csr_bus_parity_err(ctl_pe));

	hsd_adapter_model u_hsd_adapter_model (.clock(clock), .power_set(power_set), .cable_set(cable_set),
		.fatal_event(fatal_event), .hose_reset_request(hose_rst), .hose_in(hose_in));

	initial
	begin
		forever #5 clock = ~clock;
	end

	// pulses are one cycle wide, so they are collected here and judged later
	always @(posedge clock)
	begin
		if (irq === 1'b1)
			irq_cnt++;
		if (ctl_pe === 1'b1)
			ctl_cnt++;
		// only this process writes the collector; the stimulus merely asks for a fresh start
		pe_seen <= pe_clear ? pe_err : (pe_seen | pe_err);
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic access(input logic wr, input logic [15:0] off, input logic [31:0] wd);
		@(negedge clock);
		req <= '{1'b1, wr, off, wd};
		pe_clear = 0;
		@(negedge clock);
		req <= '0;
		rdata = csr_rdata;
		check({31'h0, csr_ack}, 32'h1);
	endtask

	task automatic rd(input logic [15:0] off, input logic [31:0] exp);
		access(1'b0, off, 32'h0);
		check(rdata, exp);
	endtask

	task automatic settle();
		repeat (2) @(negedge clock);
	endtask

	task automatic print_verdict();
		if (error_cnt == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial
	begin
		#100000;
		error_cnt++;
		print_verdict();
	end

	initial
	begin
		repeat (2) @(negedge clock);
		reset = 0;
		power_up_reset = 0;
		for (int n = 0; n < 4; n++)
		begin
			rd(STAT[n], {29'h0, cable_set[n], 2'b00});
			rd(DIAG[n], DIAG_RESET);
		end
		rd(OFF_VECTOR, 32'h0);
		irq_en = 1;
		power_set[1] = 1'b1;
		settle();
		check(32'(irq_cnt), 32'h1);
		rd(STAT[1], 32'h0000_000a);
		access(1'b1, STAT[1], 32'h0);
		rd(STAT[1], 32'h0000_000a);
		access(1'b1, STAT[1], 32'h8);
		rd(STAT[1], 32'h0000_0002);
		irq_en = 0;
		power_set[1] = 1'b0;
		settle();
		check(32'(irq_cnt), 32'h1);
		rd(STAT[1], 32'h0000_0008);
		irq_en = 1;
		fatal_event[2] = 1'b1;
		@(negedge clock);
		fatal_event[2] = 1'b0;
		settle();
		check(32'(irq_cnt), 32'h2);
		rd(STAT[2], 32'h0000_0001);
		access(1'b1, STAT[2], 32'h8000_0000);
		check({28'h0, hose_rst}, 32'h4);
		settle();
		rd(STAT[2], 32'h0);
		access(1'b1, DIAG[0], 32'hffff_ff03);
		check({19'h0, force_ctl[0]}, 32'h1f03);
		pe_clear = 1;
		rd(DIAG[0], 32'hc01d_0003);
		settle();
		check({28'h0, pe_seen}, 32'h1);
		check({31'h0, force_ctl[0].csr_addr_parity}, 32'h0);
		check({28'h0, mu, md, lu, ld}, 32'h8);
		ecc_in = 8'ha0;
		read_return_valid = 1;
		@(negedge clock);
		read_return_valid = 0;
		check({24'h0, ecc_out}, 32'ha3);
		wr_target = 4'b0010;
		pe_clear = 1;
		access(1'b1, DIAG[1], 32'h8000_0000);
		wr_target = 4'h0;
		settle();
		check({28'h0, pe_seen}, 32'h2);
		check({28'h0, mu, md, lu, ld}, 32'h0);
		access(1'b1, 16'h2b00, 32'h0);
		settle();
		check(32'(ctl_cnt), 32'h1);
		access(1'b1, DIAG[3], 32'h8000_0000);
		check({28'h0, mu, md, lu, ld}, 32'h1);
		reset = 1;
		node_reset_active = 1;
		power_set[0] = 1'b1;
		settle();
		check({28'h0, dn_rst_n}, 32'h1);
		reset = 0;
		node_reset_active = 0;
		rd(DIAG[0], 32'hc000_0000);
		rd(STAT[0], 32'h0000_0006);
		check(32'(irq_cnt), 32'h2);
		reset = 1;
		power_up_reset = 1;
		settle();
		reset = 0;
		power_up_reset = 0;
		rd(DIAG[0], 32'h0);
		access(1'b1, DIAG[2], 32'h4001_0000);
		rd_target = 4'b0100;
		pe_clear = 1;
		rd(DIAG[2], 32'h4001_0000);
		rd_target = 4'h0;
		settle();
		check({28'h0, pe_seen}, 32'h1);
		node_reset_active = 1;
		@(negedge clock);
		check({28'h0, dn_rst_n}, 32'h4);
		node_reset_active = 0;
		access(1'b1, OFF_VECTOR, 32'h1234_abcd);
		rd(OFF_VECTOR, 32'h0000_abcd);
		level3_ident_read = 1;
		@(negedge clock);
		level3_ident_read = 0;
		check({16'h0, ident}, 32'habcd);
		access(1'b1, 16'h2b00, 32'hffff_ffff);
		rd(16'h2b00, 32'h0);
		check(32'(ctl_cnt), 32'h1);
		ce = 0;
		power_set[3] = 1'b1;
		@(negedge clock);
		power_set[3] = 1'b0;
		ce = 1;
		settle();
		rd(STAT[3], 32'h0000_0004);
		check(32'(irq_cnt), 32'h2);
		print_verdict();
	end
endmodule // hsd_regs_tb
